// *** common/mcf_pkg.sv ***
// Package of constants and carrier types for the motion command frame interpreter
package mcf_pkg;

    // ------------------------------------------------------------
    // Frame layout
    // ------------------------------------------------------------
    localparam int unsigned MCF_CORE_LEN = 7;
    localparam int unsigned MCF_SER_LEN = 9;
    localparam logic [3:0] MCF_SER_LAST = 4'h8;
    localparam logic [3:0] MCF_CAN_LAST = 4'h6;
    localparam logic [3:0] MCF_POS_ADDR = 4'h0;
    localparam logic [3:0] MCF_POS_CMD = 4'h1;
    localparam logic [3:0] MCF_POS_TYPE = 4'h2;
    localparam logic [3:0] MCF_POS_SEL = 4'h3;
    localparam logic [3:0] MCF_POS_VAL0 = 4'h4;

    // ------------------------------------------------------------
    // Status codes
    // ------------------------------------------------------------
    localparam logic [7:0] MCF_ST_OK = 8'h64;
    localparam logic [7:0] MCF_ST_STORED = 8'h65;
    localparam logic [7:0] MCF_ST_BAD_SUM = 8'h01;
    localparam logic [7:0] MCF_ST_BAD_CMD = 8'h02;
    localparam logic [7:0] MCF_ST_BAD_TYPE = 8'h03;
    localparam logic [7:0] MCF_ST_BAD_VAL = 8'h04;
    localparam logic [7:0] MCF_ST_LOCKED = 8'h05;
    localparam logic [7:0] MCF_ST_NOT_AVAIL = 8'h06;

    // ------------------------------------------------------------
    // Reset values and sizes
    // ------------------------------------------------------------
    localparam int unsigned MCF_FIFO_DEPTH = 8;
    localparam logic [3:0] MCF_IDX_RST = 4'h0;
    localparam logic [7:0] MCF_BYTE_RST = 8'h00;

    // ------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic [7:0] cmd;
        logic [7:0] typ;
        logic [7:0] sel;
        logic [31:0] value;
    } mcf_cmd_type;

    typedef struct packed {
        logic [7:0] status;
        logic [31:0] value;
    } mcf_result_type;

endpackage : mcf_pkg

// *** design/mcf_fifo.sv ***
// Parameterised valid/ready FIFO for received frame bytes
`timescale 1ns/1ps
module mcf_fifo import mcf_pkg::*; #(
    parameter int unsigned WIDTH = 8,
    parameter int unsigned DEPTH = MCF_FIFO_DEPTH
) (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rst_b,
    // Fill side
    input wire logic i_in_valid,
    input wire logic [WIDTH-1:0] i_in_data,
    output logic o_in_ready,
    // Drain side
    output logic o_out_valid,
    output logic [WIDTH-1:0] o_out_data,
    input wire logic i_out_ready
);
    localparam int unsigned AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_ff [DEPTH];
    logic [AW-1:0] wr_ff, nxt_wr;
    logic [AW-1:0] rd_ff, nxt_rd;
    logic [AW:0] cnt_ff, nxt_cnt;
    logic push;
    logic pop;

    // ------------------------------------------------------------
    // Pointers
    // ------------------------------------------------------------
    always_comb begin
        push = i_in_valid && (cnt_ff != (AW+1)'(DEPTH));
        pop = i_out_ready && (cnt_ff != '0);
        nxt_wr = push ? AW'(wr_ff + 1'b1) : wr_ff;
        nxt_rd = pop ? AW'(rd_ff + 1'b1) : rd_ff;
        nxt_cnt = cnt_ff;
        if (push && !pop) begin
            nxt_cnt = (AW+1)'(cnt_ff + 1'b1);
        end else if (pop && !push) begin
            nxt_cnt = (AW+1)'(cnt_ff - 1'b1);
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_rst_b) begin
            wr_ff <= '0;
            rd_ff <= '0;
            cnt_ff <= '0;
        end else begin
            wr_ff <= nxt_wr;
            rd_ff <= nxt_rd;
            cnt_ff <= nxt_cnt;
        end
    end

    always_ff @(posedge i_clk) begin
        if (push) begin
            mem_ff[wr_ff] <= i_in_data;
        end
    end

    assign o_in_ready = (cnt_ff != (AW+1)'(DEPTH));
    assign o_out_valid = (cnt_ff != '0);
    assign o_out_data = mem_ff[rd_ff];

    a_fifo_no_over: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        cnt_ff <= (AW+1)'(DEPTH)) else $error("FIFO count above depth");

endmodule : mcf_fifo

// *** design/mcf_interp.sv ***
// Command frame interpreter: receive, check, execute, reply
//
// Contract
// - Core command is seven bytes: command, type, selector, four value bytes.
// - Serial frames add a leading address byte and trailing checksum: nine bytes.
// - Serial order: address, command, type, selector, value MSB first, checksum.
// - Command checksum is 8-bit wrapping sum of all preceding bytes incl. address.
// - CAN frames carry neither address nor checksum byte.
// - Device executes the command fully before sending its reply.
// - Device transmits only as a reply; never unsolicited.
// - Serial reply: reply addr, module addr, status, command, value MSB first, sum.
// - Reply checksum is 8-bit wrapping sum of all other reply bytes.
// - CAN reply carries neither address nor checksum byte.
// - Status 100 means executed, 101 means stored into program memory.
// - Errors: 1 checksum, 2 command, 3 type, 4 value, 5 locked, 6 unavailable.
`timescale 1ns/1ps
module mcf_interp import mcf_pkg::*; (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rst_b,
    // Configuration
    input wire logic i_can_mode,
    input wire logic [7:0] i_module_addr,
    input wire logic [7:0] i_reply_addr,
    // Receive byte stream
    input wire logic i_rx_valid,
    input wire logic [7:0] i_rx_data,
    output logic o_rx_ready,
    // Execution port
    output logic o_exec_req,
    output mcf_cmd_type o_exec_cmd,
    input wire logic i_exec_done,
    input wire mcf_result_type i_exec_result,
    // Transmit byte stream
    output logic o_tx_valid,
    output logic [7:0] o_tx_data,
    output logic o_tx_last,
    input wire logic i_tx_ready,
    // Bus direction
    output logic o_tx_enable
);

    typedef enum logic [3:0] {
        ST_RX = 4'h1,
        ST_EXEC = 4'h2,
        ST_TX = 4'h4,
        ST_WAIT = 4'h8
    } mcf_state_type;

    function automatic logic [3:0] last_idx(input logic can);
        last_idx = can ? MCF_CAN_LAST : MCF_SER_LAST;
    endfunction : last_idx

    mcf_state_type state_ff, nxt_state;
    logic [3:0] idx_ff, nxt_idx;
    logic [7:0] sum_ff, nxt_sum;
    logic [7:0] addr_ff, nxt_addr;
    mcf_cmd_type cmd_ff, nxt_cmd;
    logic [7:0] status_ff, nxt_status;
    logic [31:0] rval_ff, nxt_rval;
    logic can_ff, nxt_can;
    logic req_ff, nxt_req;
    logic txv_ff, nxt_txv;
    logic [7:0] txd_ff, nxt_txd;
    logic txl_ff, nxt_txl;
    logic [7:0] rsum_ff, nxt_rsum;
    logic f_valid;
    logic [7:0] f_data;
    logic f_ready;
    logic [3:0] pos;
    logic [7:0] rbyte;

    // ------------------------------------------------------------
    // Receive buffer
    // ------------------------------------------------------------
    mcf_fifo #(.WIDTH(8), .DEPTH(MCF_FIFO_DEPTH)) u_rx_fifo (
        .i_clk(i_clk),
        .i_rst_b(i_rst_b),
        .i_in_valid(i_rx_valid),
        .i_in_data(i_rx_data),
        .o_in_ready(o_rx_ready),
        .o_out_valid(f_valid),
        .o_out_data(f_data),
        .i_out_ready(f_ready)
    );

    assign f_ready = (state_ff == ST_RX);

    // ------------------------------------------------------------
    // Frame state machine
    // ------------------------------------------------------------
    always_comb begin
        nxt_state = state_ff;
        nxt_idx = idx_ff;
        nxt_sum = sum_ff;
        nxt_addr = addr_ff;
        nxt_cmd = cmd_ff;
        nxt_status = status_ff;
        nxt_rval = rval_ff;
        nxt_can = can_ff;
        nxt_req = 1'b0;
        nxt_txv = txv_ff;
        nxt_txd = txd_ff;
        nxt_txl = txl_ff;
        nxt_rsum = rsum_ff;
        pos = can_ff ? 4'(idx_ff + 4'h1) : idx_ff;
        rbyte = MCF_BYTE_RST;
        case (state_ff)
            ST_RX: begin
                if (idx_ff == MCF_IDX_RST) begin
                    nxt_can = i_can_mode;
                    pos = i_can_mode ? MCF_POS_CMD : MCF_POS_ADDR;
                end
                if (f_valid) begin
                    nxt_sum = 8'(sum_ff + f_data);
                    nxt_idx = 4'(idx_ff + 4'h1);
                    case (pos)
                        MCF_POS_ADDR: nxt_addr = f_data;
                        MCF_POS_CMD: nxt_cmd.cmd = f_data;
                        MCF_POS_TYPE: nxt_cmd.typ = f_data;
                        MCF_POS_SEL: nxt_cmd.sel = f_data;
                        MCF_SER_LAST: nxt_cmd.value = cmd_ff.value;
                        default: nxt_cmd.value = {cmd_ff.value[23:0], f_data};
                    endcase
                    if (idx_ff == last_idx(nxt_can)) begin
                        nxt_idx = MCF_IDX_RST;
                        nxt_sum = MCF_BYTE_RST;
                        if (nxt_can) begin
                            nxt_state = ST_EXEC;
                            nxt_req = 1'b1;
                        end else if (addr_ff != i_module_addr) begin
                            nxt_state = ST_RX;
                        end else if (f_data != sum_ff) begin
                            nxt_status = MCF_ST_BAD_SUM;
                            nxt_rval = '0;
                            nxt_state = ST_TX;
                        end else begin
                            nxt_state = ST_EXEC;
                            nxt_req = 1'b1;
                        end
                    end
                end
            end
            ST_EXEC: begin
                if (i_exec_done) begin
                    nxt_status = i_exec_result.status;
                    nxt_rval = i_exec_result.value;
                    nxt_state = ST_TX;
                end
            end
            ST_TX: begin
                if (!txv_ff || i_tx_ready) begin
                    case (pos)
                        4'h0: rbyte = i_reply_addr;
                        4'h1: rbyte = i_module_addr;
                        4'h2: rbyte = status_ff;
                        4'h3: rbyte = cmd_ff.cmd;
                        4'h4: rbyte = rval_ff[31:24];
                        4'h5: rbyte = rval_ff[23:16];
                        4'h6: rbyte = rval_ff[15:8];
                        4'h7: rbyte = rval_ff[7:0];
                        default: rbyte = rsum_ff;
                    endcase
                    if (can_ff) begin
                        pos = 4'(idx_ff + 4'h2);
                        case (pos)
                            4'h2: rbyte = status_ff;
                            4'h3: rbyte = cmd_ff.cmd;
                            4'h4: rbyte = rval_ff[31:24];
                            4'h5: rbyte = rval_ff[23:16];
                            4'h6: rbyte = rval_ff[15:8];
                            default: rbyte = rval_ff[7:0];
                        endcase
                    end
                    nxt_txv = 1'b1;
                    nxt_txd = rbyte;
                    nxt_rsum = 8'(rsum_ff + rbyte);
                    nxt_txl = (idx_ff == (can_ff ? 4'h5 : MCF_SER_LAST));
                    nxt_idx = 4'(idx_ff + 4'h1);
                    if (nxt_txl) begin
                        nxt_state = ST_WAIT;
                    end
                end
            end
            ST_WAIT: begin
                if (i_tx_ready) begin
                    nxt_txv = 1'b0;
                    nxt_txl = 1'b0;
                    nxt_idx = MCF_IDX_RST;
                    nxt_rsum = MCF_BYTE_RST;
                    nxt_state = ST_RX;
                end
            end
            default: begin
                nxt_state = ST_RX;
                nxt_idx = MCF_IDX_RST;
            end
        endcase
    end

    always_ff @(posedge i_clk) begin
        if (!i_rst_b) begin
            state_ff <= ST_RX;
            idx_ff <= MCF_IDX_RST;
            sum_ff <= MCF_BYTE_RST;
            addr_ff <= MCF_BYTE_RST;
            cmd_ff <= '0;
            status_ff <= MCF_BYTE_RST;
            rval_ff <= '0;
            can_ff <= 1'b0;
            req_ff <= 1'b0;
            txv_ff <= 1'b0;
            txd_ff <= MCF_BYTE_RST;
            txl_ff <= 1'b0;
            rsum_ff <= MCF_BYTE_RST;
        end else begin
            state_ff <= nxt_state;
            idx_ff <= nxt_idx;
            sum_ff <= nxt_sum;
            addr_ff <= nxt_addr;
            cmd_ff <= nxt_cmd;
            status_ff <= nxt_status;
            rval_ff <= nxt_rval;
            can_ff <= nxt_can;
            req_ff <= nxt_req;
            txv_ff <= nxt_txv;
            txd_ff <= nxt_txd;
            txl_ff <= nxt_txl;
            rsum_ff <= nxt_rsum;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign o_exec_req = req_ff;
    assign o_exec_cmd = cmd_ff;
    assign o_tx_valid = txv_ff;
    assign o_tx_data = txd_ff;
    assign o_tx_last = txl_ff;
    assign o_tx_enable = txv_ff;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    a_tx_only_reply: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        $rose(txv_ff) |-> $past(state_ff) == ST_TX)
        else $error("Transmit started outside a reply");
    a_exec_before_tx: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        (state_ff == ST_EXEC && !i_exec_done) |=> !txv_ff)
        else $error("Reply sent before execution done");
    a_bad_sum_status: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        ($past(state_ff) == ST_RX && state_ff == ST_TX) |-> status_ff == MCF_ST_BAD_SUM)
        else $error("Checksum error not reported");
    a_req_one_cycle: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        req_ff |-> state_ff == ST_EXEC ##1 !req_ff)
        else $error("Execute request not a single pulse");
    a_last_is_sum: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        ($rose(txl_ff) && !can_ff) |-> txd_ff == $past(rsum_ff))
        else $error("Reply checksum wrong");
    a_first_reply_byte: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        ($rose(txv_ff) && !can_ff) |-> txd_ff == i_reply_addr)
        else $error("Reply does not start with reply address");
    a_can_first_status: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        ($rose(txv_ff) && can_ff) |-> txd_ff == status_ff)
        else $error("CAN reply does not start with status");
    a_no_tx_in_rx: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        state_ff == ST_RX |-> !txv_ff)
        else $error("Bus driven while receiving");

endmodule : mcf_interp

// *** verification/mcf_host_model.sv ***
// Host-side model: sends command frames and collects reply bytes
`timescale 1ns/1ps
module mcf_host_model (
    // Clock
    input wire logic i_clk,
    // Command byte stream
    output logic o_rx_valid,
    output logic [7:0] o_rx_data,
    input wire logic i_rx_ready,
    // Reply byte stream
    input wire logic i_tx_valid,
    input wire logic [7:0] i_tx_data,
    input wire logic i_tx_last,
    output logic o_tx_ready
);
    initial begin
        o_rx_valid = 1'b0;
        o_rx_data = 8'h5a;
        o_tx_ready = 1'b0;
    end

    // ------------------------------------------------------------
    // Frame send, bytes in order, each held until taken
    // ------------------------------------------------------------
    task automatic send(input logic [7:0] b [9], input int n, output bit ok);
        int t;
        ok = 1'b1;
        @(posedge i_clk);
        for (int i = 0; i < n; i++) begin
            o_rx_valid <= 1'b1;
            o_rx_data <= b[i];
            t = 0;
            do begin
                @(posedge i_clk);
                t++;
            end while (i_rx_ready !== 1'b1 && t < 100);
            if (t >= 100) begin
                ok = 1'b0;
            end
        end
        o_rx_valid <= 1'b0;
        o_rx_data <= ~b[n-1];
    endtask : send

    // ------------------------------------------------------------
    // Reply collection with random stalls
    // ------------------------------------------------------------
    task automatic recv(output logic [7:0] q [$], output bit ok);
        q = {};
        ok = 1'b0;
        for (int n = 0; n < 300; n++) begin
            @(posedge i_clk);
            if (i_tx_valid === 1'b1 && o_tx_ready === 1'b1) begin
                q.push_back(i_tx_data);
                if (i_tx_last === 1'b1) begin
                    ok = 1'b1;
                    o_tx_ready <= 1'b0;
                    return;
                end
            end
            o_tx_ready <= 1'($urandom_range(0, 1));
        end
    endtask : recv
endmodule : mcf_host_model

// *** verification/mcf_interp_tb_top.sv ***
// Self-checking testbench for the command frame interpreter and its FIFO
`timescale 1ns/1ps
module mcf_interp_tb_top import mcf_pkg::*; ;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic can_mode = 1'b0;
    logic [7:0] mod_addr = 8'h00;
    logic [7:0] rep_addr = 8'h00;
    logic rx_valid, rx_ready, exec_req, tx_valid, tx_last, tx_ready, tx_en;
    logic [7:0] rx_data, tx_data;
    mcf_cmd_type exec_cmd;
    logic exec_done = 1'b0;
    mcf_result_type exec_res = '0;
    int failures = 0;
    int cmp_count = 0;
    int req_seen = 0;
    bit expect_reply = 1'b0;
    logic [7:0] frm [9];
    int flen;
    logic [7:0] sts [7] = '{MCF_ST_OK, MCF_ST_STORED, MCF_ST_BAD_CMD, MCF_ST_BAD_TYPE,
                            MCF_ST_BAD_VAL, MCF_ST_LOCKED, MCF_ST_NOT_AVAIL};

    always #12.5 clk = ~clk;

    mcf_interp dut_u (.i_clk(clk), .i_rst_b(rst_b), .i_can_mode(can_mode),
        .i_module_addr(mod_addr), .i_reply_addr(rep_addr), .i_rx_valid(rx_valid),
        .i_rx_data(rx_data), .o_rx_ready(rx_ready), .o_exec_req(exec_req),
        .o_exec_cmd(exec_cmd), .i_exec_done(exec_done), .i_exec_result(exec_res),
        .o_tx_valid(tx_valid), .o_tx_data(tx_data), .o_tx_last(tx_last),
        .i_tx_ready(tx_ready), .o_tx_enable(tx_en));
    mcf_host_model host_u (.i_clk(clk), .o_rx_valid(rx_valid), .o_rx_data(rx_data),
        .i_rx_ready(rx_ready), .i_tx_valid(tx_valid), .i_tx_data(tx_data),
        .i_tx_last(tx_last), .o_tx_ready(tx_ready));

    // ------------------------------------------------------------
    // Checking and closing
    // ------------------------------------------------------------
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            failures++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    task automatic wrap_up();
        if (failures == 0 && cmp_count > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : wrap_up

    task automatic give_up();
        failures++;
        wrap_up();
    endtask : give_up

    always @(posedge clk) begin
        if (exec_req === 1'b1) begin
            req_seen++;
        end
        if (rst_b === 1'b1 && (tx_en === 1'b1 || tx_valid === 1'b1)) begin
            chk(32'(expect_reply), 32'h1);
            chk(32'(tx_en), 32'h1);
        end
    end

    // ------------------------------------------------------------
    // Frame building and one command round trip
    // ------------------------------------------------------------
    task automatic build(input logic can, input logic [7:0] adr, input mcf_cmd_type c,
                         input logic [7:0] bad);
        int k;
        logic [7:0] s;
        k = can ? 0 : 1;
        frm[0] = adr;
        frm[k] = c.cmd;
        frm[k+1] = c.typ;
        frm[k+2] = c.sel;
        for (int j = 0; j < 4; j++) frm[k+3+j] = c.value[31-8*j -: 8];
        flen = k + 7;
        if (!can) begin
            s = 8'h00;
            for (int j = 0; j < 8; j++) s += frm[j];
            frm[8] = s + bad;
            flen = 9;
        end
    endtask : build

    task automatic run(input logic can, input bit alien, input logic [7:0] bad,
                       input logic [7:0] st);
        mcf_cmd_type c;
        logic [7:0] rep [$];
        logic [7:0] e [$];
        logic [7:0] s;
        logic [31:0] v;
        int n0, n;
        bit ok;
        c.cmd = 8'($urandom_range(1, 200));
        c.typ = 8'($urandom);
        c.sel = 8'($urandom);
        c.value = $urandom;
        v = (bad != 8'h00) ? 32'h0 : $urandom;
        build(can, alien ? mod_addr + 8'h01 : mod_addr, c, bad);
        n0 = req_seen;
        expect_reply = !alien;
        host_u.send(frm, flen, ok);
        if (!ok) give_up();
        if (alien) begin
            repeat (40) @(posedge clk);
            chk(32'(req_seen - n0), 32'h0);
            return;
        end
        if (bad == 8'h00) begin
            for (n = 0; n < 40 && req_seen == n0; n++) begin
                @(posedge clk);
                #1;
                chk(32'(tx_valid), 32'h0);
            end
            if (n >= 40) give_up();
            chk(32'({exec_cmd.cmd, exec_cmd.typ, exec_cmd.sel}), 32'({c.cmd, c.typ, c.sel}));
            chk(exec_cmd.value, c.value);
            repeat ($urandom_range(0, 3)) begin
                @(posedge clk);
                #1;
                chk(32'(tx_valid), 32'h0);
            end
            @(posedge clk);
            exec_done <= 1'b1;
            exec_res <= '{status: st, value: v};
            @(posedge clk);
            exec_done <= 1'b0;
            exec_res <= ~exec_res;
        end
        host_u.recv(rep, ok);
        if (!ok) give_up();
        @(posedge clk);
        expect_reply = 1'b0;
        if (!can) e = {rep_addr, mod_addr};
        e.push_back(bad != 8'h00 ? MCF_ST_BAD_SUM : st);
        e.push_back(c.cmd);
        for (int j = 0; j < 4; j++) e.push_back(v[31-8*j -: 8]);
        s = 8'h00;
        foreach (e[i]) s += e[i];
        if (!can) e.push_back(s);
        chk(32'(rep.size()), 32'(e.size()));
        foreach (e[i]) if (i < rep.size()) chk(32'(rep[i]), 32'(e[i]));
        if (bad != 8'h00) chk(32'(req_seen - n0), 32'h0);
    endtask : run

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        void'($urandom(32'h329a));
        repeat (5) @(posedge clk);
        rst_b <= 1'b1;
        mod_addr <= 8'($urandom);
        rep_addr <= 8'($urandom);
        @(posedge clk);
        #1;
        chk(32'(rx_ready), 32'h1);
        chk(32'(tx_valid), 32'h0);
        chk(32'(tx_en), 32'h0);
        chk(32'(tx_last), 32'h0);
        chk(32'(exec_req), 32'h0);
        foreach (sts[i]) run(1'b0, 1'b0, 8'h00, sts[i]);
        run(1'b0, 1'b0, 8'h01, MCF_ST_OK);
        run(1'b0, 1'b0, 8'h80, MCF_ST_OK);
        run(1'b0, 1'b1, 8'h00, MCF_ST_OK);
        @(posedge clk);
        can_mode <= 1'b1;
        foreach (sts[i]) run(1'b1, 1'b0, 8'h00, sts[i]);
        @(posedge clk);
        can_mode <= 1'b0;
        repeat (20) run(1'b0, 1'b0, 8'h00, sts[$urandom_range(0, 6)]);
        run(1'b0, 1'b1, 8'h00, MCF_ST_OK);
        run(1'b0, 1'b0, 8'h00, MCF_ST_OK);
        @(posedge clk);
        #1;
        chk(32'(rx_ready), 32'h1);
        chk(32'(tx_en), 32'h0);
        wrap_up();
    end
endmodule : mcf_interp_tb_top
